// ===== hw/spl_pkg.sv
// Constants shared by the servo position loop and its encoder counter.
// Assumes a 50 MHz system clock and 8-bit APB byte addresses.
package spl_pkg;
	localparam int CLK_PERIOD_NS = 20;
	localparam int T_1MS_NS = 1000000;
	localparam int T_2MS_NS = 2000000;
	localparam int T_500US_NS = 500000;
	localparam int T_200US_NS = 200000;
	localparam int T_100US_NS = 100000;
	localparam int CYC_1MS = T_1MS_NS / CLK_PERIOD_NS;
	localparam int CYC_2MS = T_2MS_NS / CLK_PERIOD_NS;
	localparam int CYC_500US = T_500US_NS / CLK_PERIOD_NS;
	localparam int CYC_200US = T_200US_NS / CLK_PERIOD_NS;
	localparam int CYC_100US = T_100US_NS / CLK_PERIOD_NS;

	localparam logic [2:0] PER_1MS = 3'h0;
	localparam logic [2:0] PER_2MS = 3'h1;
	localparam logic [2:0] PER_500US = 3'h2;
	localparam logic [2:0] PER_200US = 3'h3;
	localparam logic [2:0] PER_100US = 3'h4;

	localparam logic [1:0] IMODE_NEVER = 2'h0;
	localparam logic [1:0] IMODE_ALWAYS = 2'h1;
	localparam logic [1:0] IMODE_SMART = 2'h2;
	localparam logic [1:0] IMODE_STEADY = 2'h3;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PROPORTIONAL_GAIN = 8'h04;
	localparam logic [7:0] ADDR_VELOCITY_FEEDBACK_GAIN = 8'h08;
	localparam logic [7:0] ADDR_KDER = 8'h0c;
	localparam logic [7:0] ADDR_INTEGRAL_GAIN = 8'h10;
	localparam logic [7:0] ADDR_ILIM = 8'h14;
	localparam logic [7:0] ADDR_KVFF = 8'h18;
	localparam logic [7:0] ADDR_KACC = 8'h1c;
	localparam logic [7:0] ADDR_POS = 8'h20;
	localparam logic [7:0] ADDR_FERR = 8'h24;
	localparam logic [7:0] ADDR_DEMAND = 8'h28;
	localparam int CTRL_PER_LSB = 0;
	localparam int CTRL_IMODE_LSB = 4;

	localparam logic [1:0] RST_IMODE = IMODE_ALWAYS;
	localparam logic [2:0] RST_PERIOD = PER_1MS;
	localparam int GAIN_FRAC = 8;
	localparam int DAC_MAX = 2047;
	localparam int DAC_MIN = -2048;
	localparam int DAC_FULL = 2048;
	localparam int PCT_FULL = 100;
	localparam int ERR_LIM = 32767;
	localparam int IACC_LIM = 8388607;
endpackage

// ===== hw/spl_quad_counter.sv
// Four-times quadrature position counter for one encoder.
// Assumes the channel inputs are already synchronous to i_clk.
`timescale 1ns/10ps
module spl_quad_counter import spl_pkg::*; (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	output logic [31:0] o_count
);
	typedef struct packed {
		logic a_prev;
		logic b_prev;
		logic [31:0] count;
	} spl_quad_type;

	spl_quad_type r;
	spl_quad_type n;
	logic step;

	// Both channels moving at once is an illegal jump and is not counted
	always_comb begin
		n = r;
		n.a_prev = i_enc_a;
		n.b_prev = i_enc_b;
		step = i_enc_a ^ r.a_prev ^ i_enc_b ^ r.b_prev;
		if (step) begin
			if (r.a_prev ^ i_enc_b)
				n.count = r.count + 32'h1;
			else
				n.count = r.count - 32'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst)
			r <= '0;
		else
			r <= n;
	end

	assign o_count = r.count;

	property p_edge_step;
		@(posedge i_clk) disable iff (i_srst)
		step |=> (o_count - $past(o_count) == 32'h1) ||
			($past(o_count) - o_count == 32'h1);
	endproperty
	a_edge_step: assert property (p_edge_step)
		else $error("encoder edge did not move count by one");
endmodule // spl_quad_counter

// ===== hw/spl_servo_loop.sv
// Closed-loop position servo for one axis with an APB register slave.
// Assumes demand position and velocity come from a profile generator
// and hold steady between sample ticks; encoder inputs are synchronous.
`timescale 1ns/10ps
module spl_servo_loop import spl_pkg::*; #(
	parameter int P_CYC_1MS = CYC_1MS,
	parameter int P_CYC_2MS = CYC_2MS,
	parameter int P_CYC_500US = CYC_500US,
	parameter int P_CYC_200US = CYC_200US,
	parameter int P_CYC_100US = CYC_100US
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [31:0] i_demand_pos,
	input wire logic [15:0] i_demand_vel,
	input wire logic i_enc_a,
	input wire logic i_enc_b,
	output logic [11:0] o_demand_code,
	output logic o_sample_tick
);
	typedef struct packed {
		logic [16:0] div_cnt;
		logic tick;
		logic [2:0] period;
		logic [1:0] imode;
		logic [15:0] kp;
		logic [15:0] kv;
		logic [15:0] kd;
		logic [15:0] ki;
		logic [15:0] kvff;
		logic [15:0] kacc;
		logic [6:0] ilim;
		logic [31:0] err_prev;
		logic [31:0] pos_prev;
		logic [31:0] iacc;
		logic [15:0] dvel_prev;
		logic [11:0] demand;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} spl_state_type;

	spl_state_type r;
	spl_state_type n;
	logic [31:0] enc_pos;
	logic [16:0] period_limit;
	logic signed [39:0] e;
	logic signed [39:0] ep;
	logic signed [39:0] vel;
	logic signed [39:0] dv;
	logic signed [39:0] acc;
	logic signed [39:0] p_t;
	logic signed [39:0] v_t;
	logic signed [39:0] d_t;
	logic signed [39:0] iacc_n;
	logic signed [39:0] i_raw;
	logic signed [39:0] lim;
	logic signed [39:0] i_t;
	logic signed [39:0] vff_t;
	logic signed [39:0] acc_t;
	logic signed [39:0] sum;
	logic [11:0] sat;
	logic i_app;
	logic wr;
	logic [31:0] rdata;
	logic hit;

	function automatic logic signed [39:0] sx32(input logic [31:0] x);
		sx32 = {{8{x[31]}}, x};
	endfunction

	function automatic logic signed [39:0] sx16(input logic [15:0] x);
		sx16 = {{24{x[15]}}, x};
	endfunction

	function automatic logic signed [39:0] clip(
		input logic signed [39:0] v,
		input logic signed [39:0] m
	);
		if (v > m)
			clip = m;
		else if (v < -m)
			clip = -m;
		else
			clip = v;
	endfunction

	spl_quad_counter u_quad (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_enc_a(i_enc_a),
		.i_enc_b(i_enc_b),
		.o_count(enc_pos)
	);

	always_comb begin
		case (r.period)
			PER_2MS: period_limit = 17'(P_CYC_2MS);
			PER_500US: period_limit = 17'(P_CYC_500US);
			PER_200US: period_limit = 17'(P_CYC_200US);
			PER_100US: period_limit = 17'(P_CYC_100US);
			default: period_limit = 17'(P_CYC_1MS);
		endcase
	end

	// Loop arithmetic; gains are signed with eight fraction bits.
	// Error and velocity are clipped to 16 bits so products fit 40 bits.
	always_comb begin
		e = clip(sx32(i_demand_pos - enc_pos), 40'(ERR_LIM));
		ep = sx32(r.err_prev);
		vel = clip(sx32(enc_pos - r.pos_prev), 40'(ERR_LIM));
		dv = sx16(i_demand_vel);
		acc = dv - sx16(r.dvel_prev);
		p_t = (e * sx16(r.kp)) >>> GAIN_FRAC;
		v_t = (vel * sx16(r.kv)) >>> GAIN_FRAC;
		d_t = ((e - ep) * sx16(r.kd)) >>> GAIN_FRAC;
		iacc_n = clip(sx32(r.iacc) + e, 40'(IACC_LIM));
		i_raw = (iacc_n * sx16(r.ki)) >>> GAIN_FRAC;
		lim = (40'(r.ilim) * 40'(DAC_FULL)) / 40'(PCT_FULL);
		case (r.imode)
			IMODE_NEVER: i_app = 1'b0;
			IMODE_ALWAYS: i_app = 1'b1;
			IMODE_SMART: i_app = (acc == 40'sd0);
			IMODE_STEADY: i_app = (dv == 40'sd0);
			default: i_app = 1'b0;
		endcase
		i_t = i_app ? clip(i_raw, lim) : 40'sd0;
		// Feed-forward terms see demand only, so they cannot destabilise
		vff_t = (dv * sx16(r.kvff)) >>> GAIN_FRAC;
		acc_t = (acc * sx16(r.kacc)) >>> GAIN_FRAC;
		sum = p_t - v_t + d_t + i_t + vff_t + acc_t;
		if (sum > 40'(DAC_MAX))
			sat = 12'(DAC_MAX);
		else if (sum < 40'(DAC_MIN))
			sat = 12'(DAC_MIN);
		else
			sat = sum[11:0];
	end

	always_comb begin
		hit = 1'b1;
		case (i_paddr)
			ADDR_CTRL: rdata = {26'h0, r.imode, 1'b0, r.period};
			ADDR_PROPORTIONAL_GAIN: rdata = {16'h0, r.kp};
			ADDR_VELOCITY_FEEDBACK_GAIN: rdata = {16'h0, r.kv};
			ADDR_KDER: rdata = {16'h0, r.kd};
			ADDR_INTEGRAL_GAIN: rdata = {16'h0, r.ki};
			ADDR_ILIM: rdata = {25'h0, r.ilim};
			ADDR_KVFF: rdata = {16'h0, r.kvff};
			ADDR_KACC: rdata = {16'h0, r.kacc};
			ADDR_POS: rdata = enc_pos;
			ADDR_FERR: rdata = r.err_prev;
			ADDR_DEMAND: rdata = {{20{r.demand[11]}}, r.demand};
			default: begin
				rdata = 32'h0;
				hit = 1'b0;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle
	assign wr = i_psel & i_penable & r.pready & i_pwrite & ~r.pslverr;

	always_comb begin
		n = r;
		n.pready = i_psel & i_penable & ~r.pready;
		if (i_psel & i_penable & ~r.pready) begin
			n.pslverr = ~hit;
			n.prdata = i_pwrite ? 32'h0 : rdata;
		end else begin
			n.pslverr = 1'b0;
			n.prdata = 32'h0;
		end
		if (wr) begin
			case (i_paddr)
				ADDR_CTRL: begin
					n.period = i_pwdata[CTRL_PER_LSB +: 3];
					n.imode = i_pwdata[CTRL_IMODE_LSB +: 2];
				end
				ADDR_PROPORTIONAL_GAIN: n.kp = i_pwdata[15:0];
				ADDR_VELOCITY_FEEDBACK_GAIN: n.kv = i_pwdata[15:0];
				ADDR_KDER: n.kd = i_pwdata[15:0];
				ADDR_INTEGRAL_GAIN: n.ki = i_pwdata[15:0];
				ADDR_ILIM: n.ilim = i_pwdata[6:0];
				ADDR_KVFF: n.kvff = i_pwdata[15:0];
				ADDR_KACC: n.kacc = i_pwdata[15:0];
				default: n.kp = r.kp;
			endcase
		end
		// A shorter period ends the count at the new limit, or at once if already past it, rather than waiting out
		// a longer old period
		if (r.div_cnt >= period_limit - 17'h1) begin
			n.div_cnt = 17'h0;
			n.tick = 1'b1;
		end else begin
			n.div_cnt = r.div_cnt + 17'h1;
			n.tick = 1'b0;
		end
		if (r.tick) begin
			n.err_prev = e[31:0];
			n.pos_prev = enc_pos;
			n.iacc = iacc_n[31:0];
			n.dvel_prev = i_demand_vel;
			n.demand = sat;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= '0;
			r.imode <= RST_IMODE;
			r.period <= RST_PERIOD;
		end else begin
			r <= n;
		end
	end

	assign o_prdata = r.prdata;
	assign o_pready = r.pready;
	assign o_pslverr = r.pslverr;
	assign o_demand_code = r.demand;
	assign o_sample_tick = r.tick;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	property p_ferr;
		r.tick |=> r.err_prev == $past(e[31:0]);
	endproperty
	a_ferr: assert property (p_ferr)
		else $error("following error not captured at tick");

	// A shorter period written mid-count ends the old count at once if it is already past the new limit,
	// so the count at a tick may lie above the new limit
	property p_period;
		r.tick && $past(r.tick) == 1'b0 |->
			$past(r.div_cnt) >= $past(period_limit) - 17'h1;
	endproperty
	a_period: assert property (p_period)
		else $error("sample tick at wrong count");

	property p_gains_zero;
		$past(i_srst) |-> r.kp == 16'h0 && r.ki == 16'h0 &&
			o_demand_code == 12'h0 && r.ilim == 7'h0;
	endproperty
	a_gains_zero: assert property (p_gains_zero)
		else $error("gains not zero after reset");

	property p_imode_rst;
		$past(i_srst) |-> r.imode == IMODE_ALWAYS;
	endproperty
	a_imode_rst: assert property (p_imode_rst)
		else $error("integral mode not always after reset");

	property p_ilim;
		i_t <= lim && i_t >= -lim;
	endproperty
	a_ilim: assert property (p_ilim)
		else $error("integral term beyond clamp");

	property p_never;
		r.imode == IMODE_NEVER |-> i_t == 40'sd0;
	endproperty
	a_never: assert property (p_never)
		else $error("integral applied in never mode");

	property p_hold;
		!r.tick |=> $stable(o_demand_code);
	endproperty
	a_hold: assert property (p_hold)
		else $error("demand changed between ticks");

	property p_zero_out;
		r.tick && r.kp == 16'h0 && r.kv == 16'h0 && r.kd == 16'h0 &&
			r.ki == 16'h0 && r.kvff == 16'h0 && r.kacc == 16'h0
			|=> o_demand_code == 12'h0;
	endproperty
	a_zero_out: assert property (p_zero_out)
		else $error("nonzero demand with all gains zero");

	property p_apb;
		i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
	endproperty
	a_apb: assert property (p_apb)
		else $error("apb answer not one wait state");

	c_write: cover property (wr && i_paddr == ADDR_PROPORTIONAL_GAIN);
	c_sat: cover property (r.tick && sum > 40'(DAC_MAX));
	c_clamp: cover property (r.tick && i_app && i_raw > lim);
	c_fast: cover property (r.tick && r.period == PER_100US);
endmodule // spl_servo_loop

// ===== testbench/spl_enc_model.sv
// Quadrature encoder model that stands in for the motor feedback.
// Assumes the target count changes only while the axis is at rest.
`timescale 1ns/10ps
module spl_enc_model (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [31:0] i_target,
	output logic o_a,
	output logic o_b
);
	int pos;
	// One count per clock, so no step ever moves both channels at once
	always_ff @(posedge i_clk) begin
		if (i_srst)
			pos <= 0;
		else if (pos < $signed(i_target))
			pos <= pos + 1;
		else if (pos > $signed(i_target))
			pos <= pos - 1;
	end
	// Gray code, four counts to one line
	assign o_a = pos[1];
	assign o_b = pos[1] ^ pos[0];
endmodule // spl_enc_model

// ===== testbench/spl_servo_position_loop_tb.sv
// Self-checking bench for the servo loop: APB traffic and demand code.
// Assumes shortened sample periods and the encoder model on the pins.
`timescale 1ns/10ps
module spl_servo_position_loop_tb import spl_pkg::*;;
	logic i_clk, i_srst, psel, pen, pwr, pready, pslverr, tick, ea, eb;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, dpos, rnd, c;
	logic [15:0] dvel;
	logic [11:0] code;
	logic [33:0] q[$];
	int fail_count, n_checks, tgt;
	localparam int CY [6] = '{40, 80, 20, 8, 4, 40};
	localparam logic [11:0] IE [4] = '{12'h0, 12'h14, 12'h14, 12'h0};

	spl_servo_loop #(.P_CYC_1MS(40), .P_CYC_2MS(80), .P_CYC_500US(20),
		.P_CYC_200US(8), .P_CYC_100US(4)) u_dut (.i_clk(i_clk),
		.i_srst(i_srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_demand_pos(dpos),
		.i_demand_vel(dvel), .i_enc_a(ea), .i_enc_b(eb),
		.o_demand_code(code), .o_sample_tick(tick));
	spl_enc_model u_enc (.i_clk(i_clk), .i_srst(i_srst), .i_target(tgt),
		.o_a(ea), .o_b(eb));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data and error flag are noted here and judged by the monitor
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic e);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		q.push_back({w, e, d});
		@(posedge i_clk);
		pen <= 1'b1;
		n = 0;
		do @(posedge i_clk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
			fail_count++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic sample(output logic [31:0] n);
		n = 0;
		do @(posedge i_clk); while (tick !== 1'b1 && ++n < 200);
		if (n >= 200)
			fail_count++;
	endtask
	// Returns one cycle after a tick, where the new code has landed
	task automatic res(input logic [11:0] e);
		sample(c);
		@(posedge i_clk);
		chk({20'h0, code}, {20'h0, e});
	endtask
	always @(posedge i_clk) begin
		if (pready === 1'b1) begin
			chk({31'h0, pslverr}, {31'h0, q[0][32]});
			if (!q[0][33])
				chk(prdata, q[0][31:0]);
			void'(q.pop_front());
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		#400000;
		fail_count++;
		results();
	end
	initial begin
		{i_srst, psel, pen, pwr, paddr, pwdata} = {4'h8, 40'h0};
		{dpos, dvel, tgt, rnd} = {48'h0, 32'd0, 32'd14220};
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		apb(0, ADDR_CTRL, 32'h10, 0);
		for (int i = 1; i < 8; i++)
			apb(0, 8'(4 * i), 0, 0);
		apb(0, ADDR_DEMAND, 0, 0);
		apb(1, 8'h40, 1, 1);
		apb(0, 8'h3c, 0, 1);
		tgt <= 40;
		repeat (60) @(posedge i_clk);
		apb(0, ADDR_POS, 32'd40, 0);
		apb(1, ADDR_PROPORTIONAL_GAIN, 32'h100, 0);
		sample(c);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			dpos <= {{22{rnd[9]}}, rnd[9:0]};
			res(12'({{2{rnd[9]}}, rnd[9:0]} - 12'd40));
		end
		apb(0, ADDR_FERR, {{22{rnd[9]}}, rnd[9:0]} - 32'd40, 0);
		sample(c);
		dpos <= 32'd5000;
		res(12'h7ff);
		dpos <= -32'sd5000;
		res(12'h800);
		apb(1, ADDR_PROPORTIONAL_GAIN, 0, 0);
		apb(1, ADDR_KVFF, 32'h200, 0);
		{dpos, dvel} <= {32'd40, 16'd10};
		sample(c);
		res(12'd20);
		apb(1, ADDR_KVFF, 0, 0);
		apb(1, ADDR_KACC, 32'h100, 0);
		sample(c);
		dvel <= 16'd30;
		res(12'd20);
		res(12'd0);
		apb(1, ADDR_KACC, 0, 0);
		apb(1, ADDR_INTEGRAL_GAIN, 32'h100, 0);
		apb(1, ADDR_ILIM, 32'h1, 0);
		// A large error swamps whatever the accumulator held before
		dpos <= 32'd5040;
		for (int m = 0; m < 4; m++) begin
			apb(1, ADDR_CTRL, 32'(m << 4), 0);
			sample(c);
			res(IE[m]);
		end
		apb(1, ADDR_INTEGRAL_GAIN, 0, 0);
		dpos <= 32'd140;
		apb(1, ADDR_VELOCITY_FEEDBACK_GAIN, 32'h100, 0);
		sample(c);
		tgt <= 50;
		res(12'hff6);
		res(12'h0);
		apb(1, ADDR_VELOCITY_FEEDBACK_GAIN, 0, 0);
		apb(1, ADDR_KDER, 32'h100, 0);
		sample(c);
		dpos <= 32'd170;
		res(12'd30);
		res(12'd0);
		for (int p = 0; p < 6; p++) begin
			apb(1, ADDR_CTRL, 32'(p), 0);
			sample(c);
			sample(c);
			chk(c + 1, CY[p]);
		end
		results();
	end
endmodule // spl_servo_position_loop_tb
